//--- rtl/imlmno_core.sv
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
module imlmno_core
  import imlmno_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // axi4-lite write channels
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read channels
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // memory subsystem side
  input  wire logic [SYND_W-1:0] mem_syndrome,
  output logic [31:0]            mem_write_ctrl,
  output logic                   interleave_en,
  // events
  output logic                   notify_valid,
  output imlmno_notify_type      notify_req,
  output logic                   fault_uii,
  output logic                   fault_priv
);

  // ---------------------------------------------------------
  // state
  // ---------------------------------------------------------
  imlmno_state_type  state_q;
  imlmno_result_type res;
  logic [31:0]       gr_q [8];
  logic [15:0]       instr_q;
  logic [31:0]       ext_q;
  logic [31:0]       operand_q;
  logic [15:0]       keys_q;
  logic [15:0]       ecb_q;
  logic [31:0]       arg_q;
  logic [15:0]       saved_q;
  logic [31:0]       auxb_q;
  logic [SYND_W-1:0] synd_q;
  logic              priv_q;
  logic              args_q;
  logic              uii_q;
  logic              privf_q;
  logic [7:0]        awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              aw_got_q;
  logic              w_got_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic              wr_do;
  logic              go;
  logic              exec;
  logic              wr_hit;
  logic              gr_hit;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [15:0] set_cc(input logic [15:0] k,
                                         input logic [31:0] v);
    logic [15:0] r;
    r = k;
    r[KEY_LT] = v[31];
    r[KEY_EQ] = (v == 32'h0000_0000);
    return r;
  endfunction : set_cc

  function automatic logic is_restricted(input logic [15:0] op);
    return (op == OP_DEI) || (op == OP_DII) || (op == OP_DRS) ||
           (op == OP_DWC) || (op == OP_DIW) || (op == OP_NFL) ||
           (op == OP_NFF);
  endfunction : is_restricted

  // ---------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------
  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready  = !w_got_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  // writes wait while an instruction executes, so exec never races
  assign wr_do  = aw_got_q && w_got_q && !bvalid_q && (state_q == S_IDLE);
  assign gr_hit = (awaddr_q & GR_MASK) == OFS_GR_BASE;
  assign wr_hit = gr_hit || (awaddr_q == OFS_CTRL) ||
                  (awaddr_q == OFS_INSTR) || (awaddr_q == OFS_EXT) ||
                  (awaddr_q == OFS_OPERAND) || (awaddr_q == OFS_KEYS) ||
                  (awaddr_q == OFS_ECB) || (awaddr_q == OFS_ARG);
  assign go     = wr_do && (awaddr_q == OFS_CTRL) && wstrb_q[0] &&
                  wdata_q[CTRL_GO];
  assign exec   = (state_q == S_EXEC);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
      if ((s_axi_araddr & GR_MASK) == OFS_GR_BASE) begin
        rdata_q <= gr_q[s_axi_araddr[4:2]];
      end else begin
        case (s_axi_araddr)
          OFS_CTRL:    rdata_q <= {29'h0, args_q, priv_q, 1'b0};
          OFS_INSTR:   rdata_q <= {16'h0000, instr_q};
          OFS_EXT:     rdata_q <= ext_q;
          OFS_OPERAND: rdata_q <= operand_q;
          OFS_KEYS:    rdata_q <= {16'h0000, keys_q};
          OFS_ECB:     rdata_q <= {16'h0000, ecb_q};
          OFS_ARG:     rdata_q <= arg_q;
          OFS_STATUS:  rdata_q <= {28'h0, interleave_en, privf_q,
                                   uii_q, exec};
          OFS_SAVED:   rdata_q <= {16'h0000, saved_q};
          OFS_AUXB:    rdata_q <= auxb_q;
          OFS_MEMCTL:  rdata_q <= mem_write_ctrl;
          OFS_SYND:    rdata_q <= {{(32-SYND_W){1'b0}}, synd_q};
          default:     rresp_q <= RESP_SLVERR;
        endcase
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_IDLE:  state_q <= go ? S_EXEC : S_IDLE;
        S_EXEC:  state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------
  // execute
  // ---------------------------------------------------------
  always_comb begin
    logic [2:0]  r;
    logic [31:0] rv;
    logic [63:0] p64;
    logic [31:0] p32;
    r   = instr_q[9:7];
    rv  = gr_q[r];
    p64 = $signed(rv) * $signed(operand_q);
    p32 = $signed(rv[31:16]) * $signed(operand_q[15:0]);
    res = '0;
    res.idx_a = r;
    res.idx_b = r + 3'h1;
    res.keys  = keys_q;
    if (is_restricted(instr_q) && !priv_q) begin
      res.priv = 1'b1;
    end else if (instr_q == OP_NOP) begin
      res.keys = keys_q;
    end else if (instr_q == OP_NFL || instr_q == OP_NFF) begin
      res.notify = 1'b1;
    end else if (is_restricted(instr_q)) begin
      res.keys = keys_q;
    end else if (instr_q[15:7] == OP_CALL) begin
      res.keys = (keys_q & ~KEY_FLAGS) | (ecb_q & KEY_FLAGS);
      res.wr_a  = args_q;
      res.idx_a = GR_FIVE;
      res.val_a = arg_q;
      res.wr_b  = args_q;
      res.idx_b = GR_SEVN;
      res.val_b = arg_q;
    end else begin
      case (instr_q[15:10])
        MJ_GEN: begin
          if (instr_q[6:0] == SUB_ST) begin
            res.wr_a  = 1'b1;
            res.val_a = 32'h0000_0001;
            res.keys  = set_cc(keys_q, 32'h0000_0001);
          end else if (instr_q[6:0] == SUB_OK) begin
            res.keys = rv[31:16] & KEY_KEEP;
          end else if (instr_q[6:0] == SUB_PD) begin
            res.wr_a  = 1'b1;
            res.val_a = {32{rv[31]}};
            res.wr_b  = 1'b1;
            res.val_b = rv;
          end else begin
            res.unimplemented_instruction_fault = 1'b1;
          end
        end
        MJ_MUL: begin
          // even destination is the caller's duty
          res.wr_a  = 1'b1;
          res.val_a = p64[63:32];
          res.wr_b  = 1'b1;
          res.val_b = p64[31:0];
          res.keys[KEY_CARRY] = 1'b0;
        end
        MJ_MULH: begin
          res.wr_a  = 1'b1;
          res.val_a = p32;
          res.keys  = set_cc(keys_q, p32);
          res.keys[KEY_CARRY] = 1'b0;
        end
        MJ_AND: begin
          res.wr_a  = 1'b1;
          res.val_a = rv & operand_q;
        end
        MJ_ANDH: begin
          res.wr_a  = 1'b1;
          res.val_a = {rv[31:16] & operand_q[15:0], rv[15:0]};
        end
        MJ_OR: begin
          res.wr_a  = 1'b1;
          res.val_a = rv | operand_q;
        end
        MJ_ORH: begin
          res.wr_a  = 1'b1;
          res.val_a = {rv[31:16] | operand_q[15:0], rv[15:0]};
        end
        MJ_UCA, MJ_UCB: res.unimplemented_instruction_fault = 1'b1;
        default:        res.unimplemented_instruction_fault = 1'b1;
      endcase
    end
  end

  // ---------------------------------------------------------
  // register file and keys
  // ---------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        gr_q[i] <= 32'h0000_0000;
      end
      keys_q <= KEYS_RST;
    end else if (exec) begin
      if (res.wr_a) begin
        gr_q[res.idx_a] <= res.val_a;
      end
      if (res.wr_b) begin
        gr_q[res.idx_b] <= res.val_b;
      end
      keys_q <= res.keys;
    end else if (wr_do && gr_hit) begin
      gr_q[awaddr_q[4:2]] <= merge(gr_q[awaddr_q[4:2]], wdata_q, wstrb_q);
    end else if (wr_do && awaddr_q == OFS_KEYS) begin
      // keys take the whole low half, byte strobes are not honoured here
      keys_q <= wdata_q[15:0];
    end
  end

  // ---------------------------------------------------------
  // software operand registers
  // ---------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_q   <= OP_NOP;
      ext_q     <= 32'h0000_0000;
      operand_q <= 32'h0000_0000;
      ecb_q     <= KEYS_RST;
      arg_q     <= 32'h0000_0000;
      priv_q    <= 1'b0;
      args_q    <= 1'b0;
    end else if (wr_do) begin
      case (awaddr_q)
        OFS_CTRL: begin
          if (wstrb_q[0]) begin
            priv_q <= wdata_q[CTRL_PRIV];
            args_q <= wdata_q[CTRL_ARGS];
          end
        end
        OFS_INSTR:   instr_q   <= wdata_q[15:0];
        OFS_EXT:     ext_q     <= merge(ext_q, wdata_q, wstrb_q);
        OFS_OPERAND: operand_q <= merge(operand_q, wdata_q, wstrb_q);
        OFS_ECB:     ecb_q     <= wdata_q[15:0];
        OFS_ARG:     arg_q     <= merge(arg_q, wdata_q, wstrb_q);
        default:     arg_q     <= arg_q;
      endcase
    end
  end

  // ---------------------------------------------------------
  // procedure call side effects
  // ---------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      saved_q <= KEYS_RST;
      auxb_q  <= 32'h0000_0000;
    end else if (exec && instr_q[15:7] == OP_CALL) begin
      // flag fields are lost in the saved copy, as callers expect
      saved_q <= keys_q & ~KEY_FLAGS;
      if (args_q) begin
        auxb_q <= arg_q;
      end
    end
  end

  // ---------------------------------------------------------
  // memory diagnostics
  // ---------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      interleave_en  <= 1'b0;
      mem_write_ctrl <= 32'h0000_0000;
      synd_q         <= '0;
    end else if (exec && priv_q) begin
      if (instr_q == OP_DEI) begin
        interleave_en <= 1'b1;
      end
      if (instr_q == OP_DII) begin
        interleave_en <= 1'b0;
      end
      if (instr_q == OP_DRS) begin
        synd_q <= mem_syndrome;
      end
      if (instr_q == OP_DWC) begin
        mem_write_ctrl <= operand_q;
      end
    end
  end

  // ---------------------------------------------------------
  // events and sticky faults
  // ---------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      notify_valid <= 1'b0;
      notify_req   <= '0;
      fault_uii    <= 1'b0;
      fault_priv   <= 1'b0;
      uii_q        <= 1'b0;
      privf_q      <= 1'b0;
    end else begin
      notify_valid <= exec && res.notify;
      fault_uii    <= exec && res.unimplemented_instruction_fault;
      fault_priv   <= exec && res.priv;
      if (exec && res.notify) begin
        notify_req.lifo <= (instr_q == OP_NFL);
        notify_req.addr <= ext_q;
      end
      // set beats clear; go and exec never coincide anyway
      if (exec) begin
        uii_q   <= uii_q | res.unimplemented_instruction_fault;
        privf_q <= privf_q | res.priv;
      end else if (go) begin
        uii_q   <= 1'b0;
        privf_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------
  // checks
  // ---------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // privilege is sampled in the execute cycle, not at go
  sequence s_go;
    go;
  endsequence
  sequence s_notify_out;
    notify_valid ##1 !notify_valid;
  endsequence

  AST_SET_TRUE: assert property (exec && !res.unimplemented_instruction_fault && !res.priv &&
    instr_q[15:10] == MJ_GEN && instr_q[6:0] == SUB_ST |=>
    gr_q[$past(instr_q[9:7])] == 32'h0000_0001 &&
    keys_q[KEY_CARRY] == $past(keys_q[KEY_CARRY]))
    else $error("set true result or carry wrong");
  AST_MUL_CARRY: assert property (exec && instr_q[15:7] != OP_CALL &&
    !is_restricted(instr_q) && (instr_q[15:10] == MJ_MUL ||
    instr_q[15:10] == MJ_MULH) |=> !keys_q[KEY_CARRY])
    else $error("multiply left carry set");
  AST_MUL_LOW: assert property (exec && instr_q[15:10] == MJ_MUL |=>
    gr_q[$past(instr_q[9:7]) + 3'h1] ==
    $past(gr_q[instr_q[9:7]] * operand_q))
    else $error("multiply low word wrong");
  AST_DIAG_FLAGS: assert property (exec && is_restricted(instr_q) |=>
    $stable(keys_q))
    else $error("diagnostic changed keys");
  AST_PRIV: assert property (exec && is_restricted(instr_q) && !priv_q
    |=> fault_priv && !notify_valid ##1 !fault_priv)
    else $error("restricted op not refused");
  AST_UII: assert property (exec && !is_restricted(instr_q) &&
    (instr_q[15:10] == MJ_UCA || instr_q[15:10] == MJ_UCB) |=>
    fault_uii && uii_q)
    else $error("microcode op did not fault");
  AST_OTK: assert property (exec && instr_q[15:10] == MJ_GEN &&
    instr_q[6:0] == SUB_OK |=> keys_q[1:0] == 2'h0)
    else $error("output keys left low bits");
  AST_PID: assert property (exec && instr_q[15:10] == MJ_GEN &&
    instr_q[6:0] == SUB_PD |=> gr_q[$past(instr_q[9:7]) + 3'h1] ==
    $past(gr_q[instr_q[9:7]]))
    else $error("position for divide copy wrong");
  AST_NOTIFY: assert property (s_go ##1 (exec && res.notify) |=>
    s_notify_out)
    else $error("notify pulse missing");
  AST_NOP: assert property (exec && instr_q == OP_NOP |=>
    $stable(keys_q) && $stable(auxb_q))
    else $error("no operation changed state");
endmodule : imlmno_core

//--- rtl/imlmno_pkg.sv
package imlmno_pkg;

  // ---------------------------------------------------------
  // register map
  // ---------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_INSTR   = 8'h04;
  localparam logic [7:0] OFS_EXT     = 8'h08;
  localparam logic [7:0] OFS_OPERAND = 8'h0C;
  localparam logic [7:0] OFS_KEYS    = 8'h10;
  localparam logic [7:0] OFS_ECB     = 8'h14;
  localparam logic [7:0] OFS_ARG     = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1C;
  localparam logic [7:0] OFS_SAVED   = 8'h20;
  localparam logic [7:0] OFS_AUXB    = 8'h24;
  localparam logic [7:0] OFS_MEMCTL  = 8'h28;
  localparam logic [7:0] OFS_SYND    = 8'h2C;
  localparam logic [7:0] OFS_GR_BASE = 8'h40;
  localparam logic [7:0] GR_MASK     = 8'hE0;
  localparam int         CTRL_GO     = 0;
  localparam int         CTRL_PRIV   = 1;
  localparam int         CTRL_ARGS   = 2;
  localparam int         STS_BUSY    = 0;
  localparam int         STS_UII     = 1;
  localparam int         STS_PRIV    = 2;
  localparam int         STS_ILV     = 3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------
  localparam logic [15:0] OP_NOP  = 16'h0001;
  localparam logic [15:0] OP_DEI  = 16'h02C4;
  localparam logic [15:0] OP_DII  = 16'h02C5;
  localparam logic [15:0] OP_DRS  = 16'h02C6;
  localparam logic [15:0] OP_DWC  = 16'h02C7;
  localparam logic [15:0] OP_DIW  = 16'h02D4;
  localparam logic [15:0] OP_NFL  = 16'h0289;
  localparam logic [15:0] OP_NFF  = 16'h0288;
  localparam logic [8:0]  OP_CALL = 9'h131;
  localparam logic [5:0]  MJ_GEN  = 6'h18;
  localparam logic [5:0]  MJ_MUL  = 6'h22;
  localparam logic [5:0]  MJ_MULH = 6'h2A;
  localparam logic [5:0]  MJ_AND  = 6'h03;
  localparam logic [5:0]  MJ_ANDH = 6'h0B;
  localparam logic [5:0]  MJ_OR   = 6'h13;
  localparam logic [5:0]  MJ_ORH  = 6'h1B;
  localparam logic [5:0]  MJ_UCA  = 6'h34;
  localparam logic [5:0]  MJ_UCB  = 6'h3C;
  localparam logic [6:0]  SUB_ST  = 7'h0F;
  localparam logic [6:0]  SUB_OK  = 7'h39;
  localparam logic [6:0]  SUB_PD  = 7'h2A;
  localparam logic [2:0]  GR_FIVE = 3'h5;
  localparam logic [2:0]  GR_SEVN = 3'h7;

  // ---------------------------------------------------------
  // keys layout
  // ---------------------------------------------------------
  localparam int          KEY_CARRY = 15;
  localparam int          KEY_LINK  = 13;
  localparam int          KEY_LT    = 7;
  localparam int          KEY_EQ    = 6;
  localparam logic [15:0] KEY_FLAGS = 16'hA0C0;
  localparam logic [15:0] KEY_KEEP  = 16'hFFFC;
  localparam logic [15:0] KEYS_RST  = 16'h0000;
  localparam int          SYND_W    = 16;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_EXEC = 2'b01
  } imlmno_state_type;

  typedef struct packed {
    logic        lifo;
    logic [31:0] addr;
  } imlmno_notify_type;

  typedef struct packed {
    logic        wr_a;
    logic [2:0]  idx_a;
    logic [31:0] val_a;
    logic        wr_b;
    logic [2:0]  idx_b;
    logic [31:0] val_b;
    logic [15:0] keys;
    logic        unimplemented_instruction_fault;
    logic        priv;
    logic        notify;
  } imlmno_result_type;
endpackage : imlmno_pkg

//--- verification/imlmno_mem_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------
// memory subsystem stand-in
// ---------------------------------------------------------
module imlmno_mem_model
  import imlmno_pkg::*;
#(
  parameter logic [SYND_W-1:0] SYND_VAL = 16'h5A3C
) (
  // memory side
  output logic [SYND_W-1:0] mem_syndrome
);
  // mixed ones and zeros so a stuck or swapped bus shows up
  assign mem_syndrome = SYND_VAL;
endmodule : imlmno_mem_model

//--- verification/imode_logic_mul_notify_ops_test.sv
`timescale 1ns/10ps
module imode_logic_mul_notify_ops_test;
  import imlmno_pkg::*;
  // ---------------------------------------------------------
  // signals
  // ---------------------------------------------------------
  localparam logic [15:0] SYND_EXP = 16'h5A3C;
  localparam logic [7:0]  GR = OFS_GR_BASE;
  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [7:0]        awaddr = '0, araddr = '0;
  logic [31:0]       wdata = '0, rdata, mwc, rv_d;
  logic              awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic              awr, wr_rdy, bv, arr, rv, ilv, nv, fu, fp;
  logic [1:0]        bresp, rresp, rsp;
  logic [SYND_W-1:0] synd;
  imlmno_notify_type nreq, lreq;
  int                n_notify = 0, n_errors = 0, n_checks = 0;
  int                n_uii = 0, n_privf = 0;

  imlmno_core u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .mem_syndrome(synd), .mem_write_ctrl(mwc),
    .interleave_en(ilv), .notify_valid(nv), .notify_req(nreq),
    .fault_uii(fu), .fault_priv(fp));
  imlmno_mem_model #(.SYND_VAL(SYND_EXP)) u_mem (.mem_syndrome(synd));

  // ---------------------------------------------------------
  // bus tasks and checks
  // ---------------------------------------------------------
  always @(posedge ref_clk) begin
    if (nv === 1'b1) begin
      n_notify++;
      lreq <= nreq;
    end
    if (fu === 1'b1) n_uii++;
    if (fp === 1'b1) n_privf++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    rsp = bresp;
    br <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    araddr <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rdata;
    rsp = rresp;
    rr <= 1'b0;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, rv_d);
    chk(rv_d, e);
  endtask : rc
  // status is left in rv_d for the caller
  task automatic ex(input logic [15:0] op, input logic [31:0] c);
    wr(OFS_INSTR, {16'h0, op});
    wr(OFS_CTRL, c | 32'h1);
    do rd(OFS_STATUS, rv_d); while (rv_d[STS_BUSY] !== 1'b0);
  endtask : ex
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // ---------------------------------------------------------
  // clock, watchdog, tests
  // ---------------------------------------------------------
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (8000) @(posedge ref_clk);
    n_errors++;
    finish_test;
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    wr(OFS_KEYS, 32'hA0C0);
    ex({MJ_GEN, 3'h2, SUB_ST}, 32'h0);
    rc(GR + 8'h08, 32'h1);
    rc(OFS_KEYS, 32'hA000);
    wr(GR + 8'h10, 32'hFFFFFFFE);
    wr(OFS_OPERAND, 32'h00010000);
    ex({MJ_MUL, 3'h4, 7'h00}, 32'h0);
    rc(GR + 8'h10, 32'hFFFFFFFF);
    rc(GR + 8'h14, 32'hFFFE0000);
    rc(OFS_KEYS, 32'h2000);
    wr(OFS_KEYS, 32'h8000);
    wr(GR + 8'h04, 32'h00031234);
    wr(OFS_OPERAND, 32'h0000FFFE);
    ex({MJ_MULH, 3'h1, 7'h00}, 32'h0);
    rc(GR + 8'h04, 32'hFFFFFFFA);
    rc(OFS_KEYS, 32'h0080);
    $display("test multiply done");
    wr(GR + 8'h0C, 32'hF0F0F0F0);
    wr(OFS_OPERAND, 32'h0FF0FF00);
    ex({MJ_AND, 3'h3, 7'h00}, 32'h0);
    rc(GR + 8'h0C, 32'h00F0F000);
    wr(OFS_OPERAND, 32'h0000F3C0);
    ex({MJ_ANDH, 3'h3, 7'h00}, 32'h0);
    rc(GR + 8'h0C, 32'h00C0F000);
    wr(OFS_OPERAND, 32'h0000000F);
    ex({MJ_OR, 3'h3, 7'h00}, 32'h0);
    wr(OFS_OPERAND, 32'h00001200);
    ex({MJ_ORH, 3'h3, 7'h00}, 32'h0);
    ex(OP_NOP, 32'h0);
    chk({31'h0, rv_d[STS_UII]}, 32'h0);
    rc(GR + 8'h0C, 32'h12C0F00F);
    rc(OFS_KEYS, 32'h0080);
    $display("test logic done");
    ex(OP_DEI, 32'h0);
    chk({31'h0, rv_d[STS_PRIV]}, 32'h1);
    chk({31'h0, ilv}, 32'h0);
    ex(OP_DEI, 32'h2);
    chk({31'h0, ilv}, 32'h1);
    ex(OP_DII, 32'h2);
    chk({31'h0, ilv}, 32'h0);
    wr(OFS_OPERAND, 32'hC0DE1234);
    ex(OP_DWC, 32'h2);
    chk(mwc, 32'hC0DE1234);
    ex(OP_DRS, 32'h2);
    rc(OFS_SYND, {16'h0, SYND_EXP});
    ex(OP_DIW, 32'h2);
    rc(OFS_KEYS, 32'h0080);
    wr(OFS_EXT, 32'h00ABCDE0);
    ex(OP_NFF, 32'h0);
    chk({31'h0, rv_d[STS_PRIV]}, 32'h1);
    chk(32'(n_privf), 32'h2);
    ex(OP_NFL, 32'h2);
    chk({31'h0, lreq.lifo}, 32'h1);
    chk(lreq.addr, 32'h00ABCDE0);
    ex(OP_NFF, 32'h2);
    chk({31'h0, lreq.lifo}, 32'h0);
    chk(32'(n_notify), 32'h2);
    $display("test restricted done");
    ex({MJ_UCA, 10'h000}, 32'h0);
    chk({31'h0, rv_d[STS_UII]}, 32'h1);
    ex({MJ_UCB, 10'h3FF}, 32'h0);
    chk({31'h0, rv_d[STS_UII]}, 32'h1);
    chk(32'(n_uii), 32'h2);
    wr(GR + 8'h18, 32'hA0C35555);
    ex({MJ_GEN, 3'h6, SUB_OK}, 32'h0);
    rc(OFS_KEYS, 32'hA0C0);
    wr(OFS_KEYS, 32'h2043);
    wr(OFS_ECB, 32'h8080);
    wr(OFS_ARG, 32'h55AA);
    ex({OP_CALL, 7'h00}, 32'h4);
    rc(OFS_KEYS, 32'h8083);
    rc(OFS_SAVED, 32'h0003);
    rc(OFS_AUXB, 32'h55AA);
    rc(GR + 8'h1C, 32'h55AA);
    wr(OFS_ARG, 32'h1111);
    ex({OP_CALL, 7'h00}, 32'h0);
    rc(GR + 8'h14, 32'h55AA);
    wr(GR, 32'h80000001);
    ex({MJ_GEN, 3'h0, SUB_PD}, 32'h0);
    rc(GR, 32'hFFFFFFFF);
    rc(GR + 8'h04, 32'h80000001);
    rc(OFS_KEYS, 32'h8083);
    rd(8'h30, rv_d);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(OFS_STATUS, 32'h0);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    $display("test control done");
    finish_test;
  end
endmodule : imode_logic_mul_notify_ops_test
